// [step_ctrl_model.sv]
// Controller model for step, direction, mode and reset pins
`timescale 1ns/1ps
`default_nettype none
module step_ctrl_model
  import step_seq_pkg::*;
(
  input wire logic aclk, // System clock
  output logic step_clk_pin = 1'b0, // Step clock
  output logic rotation_direction_sel = 1'b0, // Direction
  output logic step_res_sel_bit0 = 1'b0, // Mode bit 0
  output logic step_res_sel_bit1 = 1'b0, // Mode bit 1
  output logic step_res_sel_bit2 = 1'b0, // Mode bit 2
  output logic seq_reset_pin = 1'b0 // Logic reset
);
  // ==========================================
  // Pin tasks
  // Mode code is {bit0, bit1, bit2}; settle before the next edge
  task automatic set_pins(input logic dir, input logic [2:0] mode);
    @(posedge aclk);
    rotation_direction_sel <= dir;
    step_res_sel_bit0 <= mode[2];
    step_res_sel_bit1 <= mode[1];
    step_res_sel_bit2 <= mode[0];
    repeat (5) @(posedge aclk);
  endtask
  // One step pulse, each level held past the sync delay
  task automatic pulse();
    @(posedge aclk);
    step_clk_pin <= 1'b1;
    repeat (5) @(posedge aclk);
    step_clk_pin <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
  // Reset pulse, then a quiet gap before any step
  task automatic reset_seq();
    @(posedge aclk);
    seq_reset_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    seq_reset_pin <= 1'b0;
    repeat (RESET_TO_STEP_CYC + 5) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// [step_seq_pkg.sv]
// Constants and register map of the stepper step sequencer
package step_seq_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00; // Control word
  localparam logic [7:0] OFS_STATUS = 8'h04; // Sequencer state
  localparam logic [7:0] OFS_PHASE = 8'h08; // Phase codes
  // ==========================================================
  // Field positions
  localparam int CTRL_DUAL_BIT = 0; // Dual edge stepping enable
  localparam int ST_POS_LSB = 0; // Position, five bits
  localparam int ST_DIR_BIT = 8; // Sampled direction
  localparam int ST_MODE_LSB = 12; // Sampled mode, three bits
  localparam int ST_STBY_BIT = 16; // Logic standby
  localparam int PH_A_LSB = 0; // Phase A code, four bits
  localparam int PH_A_NEG_BIT = 4; // Phase A polarity
  localparam int PH_B_LSB = 8; // Phase B code, four bits
  localparam int PH_B_NEG_BIT = 12; // Phase B polarity
  // ==========================================================
  // Reset values and counts
  localparam logic CTRL_DUAL_RESET = 1'b0; // Rising edge only
  localparam logic [4:0] POS_RESET = 5'h00; // Starting excitation
  localparam logic [2:0] MODE_RESET = 3'h0; // Full step, code 8
  localparam int SYNC_STAGES = 2; // Pin synchroniser depth
  localparam real RESET_TO_STEP_US = 5.0; // Least gap reset to step
  localparam real CLK_MHZ = 25.0; // Clock rate
  localparam int RESET_TO_STEP_CYC = int'(RESET_TO_STEP_US * CLK_MHZ + 0.999);
  // ==========================================================
  // Mode codes, written {bit0, bit1, bit2}
  localparam logic [2:0] MSEL_FULL8 = 3'h0; // Full step, code 8
  localparam logic [2:0] MSEL_FULLF = 3'h4; // Full step, code F
  localparam logic [2:0] MSEL_HALF = 3'h2; // Half step
  localparam logic [2:0] MSEL_HALFF = 3'h6; // Half step, code F
  localparam logic [2:0] MSEL_QUARTER = 3'h1; // Quarter step
  localparam logic [2:0] MSEL_EIGHTH = 3'h5; // Eighth step
  localparam logic [2:0] MSEL_SIXTEENTH = 3'h3; // Sixteenth step
  localparam logic [2:0] MSEL_STANDBY = 3'h7; // Logic standby
  localparam logic [1:0] RESP_OKAY = 2'h0; // AXI okay
  localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI slave error
endpackage

// [stepper_step_sequencer.sv]
// Step sequencer and translator with AXI4-Lite register access
// Function
// RQ1 - Controller waits over 5 us after reset
// RQ2 - Direction and resolution come from pins
// RQ3 - Direction and mode sampled at step edge
// RQ4 - Standard variant advances on rising edges
// RQ5 - Dual edge variant advances on both edges
// RQ6 - Mode change continues from current position
// RQ7 - Cyclic 32-state phase code table
// RQ8 - Each resolution visits its own position subset
// RQ9 - Reset pin clears to starting position
// RQ10 - Three select bits decode the step mode
// RQ11 - Standby holds position, ignores step edges
// RQ12 - Position wraps cyclically both directions
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module stepper_step_sequencer
  import step_seq_pkg::*;
(
  input wire logic aclk, // System clock, 25 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic step_clk_pin, // Step clock from controller
  input wire logic rotation_direction_sel, // Low forward, high reverse
  input wire logic step_res_sel_bit0, // Mode select bit 0
  input wire logic step_res_sel_bit1, // Mode select bit 1
  input wire logic step_res_sel_bit2, // Mode select bit 2
  input wire logic seq_reset_pin, // Logic reset, active high
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [3:0] phase_a_code, // Phase A current ratio code
  output logic phase_a_neg, // Phase A reversed polarity
  output logic [3:0] phase_b_code, // Phase B current ratio code
  output logic phase_b_neg, // Phase B reversed polarity
  output logic logic_standby, // Standby mode selected
  output logic full_current_mode // Code F fixed mode in use
);
  // ==========================================================
  // Table and stepping functions
  // Phase A entry {neg, code} for a position
  function automatic logic [4:0] phase_a(input logic [4:0] p);
    logic [5:0] t;
    t = 6'h00;
    if (p < 5'd8) t = 6'd8 - {1'b0, p};
    else if (p == 5'd8) t = 6'h00;
    else if (p < 5'd24) t = {1'b0, p} - 6'd8;
    else if (p == 5'd24) t = 6'd15;
    else t = 6'd40 - {1'b0, p};
    return {(p > 5'd8), t[3:0]};
  endfunction
  // Phase B entry {neg, code} for a position
  function automatic logic [4:0] phase_b(input logic [4:0] p);
    logic [5:0] t;
    t = 6'h00;
    if (p < 5'd8) t = 6'd8 + {1'b0, p};
    else if (p < 5'd10) t = 6'd15;
    else if (p < 5'd25) t = 6'd24 - {1'b0, p};
    else t = {1'b0, p} - 6'd24;
    return {(p > 5'd24), t[3:0]};
  endfunction
  // Position stride of a mode
  function automatic logic [4:0] stride(input logic [2:0] m);
    logic [4:0] s;
    s = 5'd16;
    unique case (m)
      MSEL_HALF, MSEL_HALFF: s = 5'd8;
      MSEL_QUARTER: s = 5'd4;
      MSEL_EIGHTH: s = 5'd2;
      MSEL_SIXTEENTH: s = 5'd1;
      default: s = 5'd16;
    endcase
    return s;
  endfunction
  // ==========================================================
  // Pin synchronisers, third stage for edge detection
  logic [SYNC_STAGES:0] clk_sync_q; // Step clock pipeline
  logic [SYNC_STAGES-1:0] dir_sync_q; // Direction pipeline
  logic [SYNC_STAGES-1:0] rst_sync_q; // Reset pin pipeline
  logic [2:0] sel_meta_q; // Mode first stage
  logic [2:0] sel_sync_q; // Mode second stage
  // Shift every pin through two flip-flops, the step clock through three
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_sync_q <= '0;
      dir_sync_q <= '0;
      rst_sync_q <= '0;
      sel_meta_q <= 3'h0;
      sel_sync_q <= 3'h0;
    end
    else
    begin
      clk_sync_q <= {clk_sync_q[SYNC_STAGES-1:0], step_clk_pin};
      dir_sync_q <= {dir_sync_q[0], rotation_direction_sel};
      rst_sync_q <= {rst_sync_q[0], seq_reset_pin};
      sel_meta_q <= {step_res_sel_bit0, step_res_sel_bit1, step_res_sel_bit2};
      sel_sync_q <= sel_meta_q;
    end
  end
  // ==========================================================
  // Step decode
  logic dual_q; // Dual edge stepping enable
  logic [4:0] pos_q; // Table position
  logic [4:0] pos_d; // Next table position
  logic dir_q; // Last sampled direction
  logic [2:0] mode_q; // Last sampled mode
  wire step_rise = clk_sync_q[1] & ~clk_sync_q[2]; // Rising step edge
  wire step_fall = ~clk_sync_q[1] & clk_sync_q[2]; // Falling step edge
  wire seq_rst = rst_sync_q[1]; // Reset pin level
  wire dir_now = dir_sync_q[1]; // Direction at this edge
  wire [2:0] sel_now = sel_sync_q; // Mode at this edge
  // RQ4 RQ5 edge selection
  wire step_evt = step_rise | (dual_q & step_fall);
  // RQ11 standby gate
  wire stby_now = (sel_now == MSEL_STANDBY);
  wire [4:0] stride_now = stride(sel_now); // Stride of new mode
  wire [4:0] grid_mask = ~(stride_now - 5'd1); // Grid of new mode
  wire [4:0] pos_al = pos_q & grid_mask; // Grid point at or below
  // RQ6 RQ8 RQ12 next grid point, wrapping
  wire [4:0] pos_fwd = pos_al + stride_now;
  wire [4:0] pos_rev = (pos_q == pos_al) ? pos_q - stride_now : pos_al;
  // RQ2 direction picks traversal order
  wire [4:0] pos_step = dir_now ? pos_rev : pos_fwd;
  // RQ9 reset pin wins over stepping
  assign pos_d = seq_rst ? POS_RESET : (step_evt && !stby_now) ? pos_step : pos_q;
  wire [4:0] ent_a = phase_a(pos_d); // Phase A entry
  wire [4:0] ent_b = phase_b(pos_d); // Phase B entry
  // ==========================================================
  // Sequencer state and outputs
  // RQ3 sample direction and mode only at a step edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pos_q <= POS_RESET;
      dir_q <= 1'b0;
      mode_q <= MODE_RESET;
      phase_a_code <= 4'h8;
      phase_a_neg <= 1'b0;
      phase_b_code <= 4'h8;
      phase_b_neg <= 1'b0;
      logic_standby <= 1'b0;
      full_current_mode <= 1'b0;
    end
    else
    begin
      pos_q <= pos_d;
      if (step_evt)
      begin
        dir_q <= dir_now;
        mode_q <= sel_now;
      end
      // RQ7 RQ10 table lookup and mode flags
      phase_a_code <= ent_a[3:0];
      phase_a_neg <= ent_a[4];
      phase_b_code <= ent_b[3:0];
      phase_b_neg <= ent_b[4];
      logic_standby <= stby_now;
      full_current_mode <= (sel_now == MSEL_FULLF) || (sel_now == MSEL_HALFF);
    end
  end
  // ==========================================================
  // AXI4-Lite slave
  logic [7:0] awaddr_q; // Captured write address
  logic [31:0] wdata_q; // Captured write data
  logic [3:0] wstrb_q; // Captured strobes
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid; // Both halves held
  wire wr_ctrl = (awaddr_q == OFS_CTRL); // Control write hit
  wire wr_ok = wr_ctrl || (awaddr_q == OFS_STATUS) || (awaddr_q == OFS_PHASE);
  wire rd_ctrl = (s_axi_araddr == OFS_CTRL); // Control read hit
  wire rd_stat = (s_axi_araddr == OFS_STATUS); // Status read hit
  wire rd_phase = (s_axi_araddr == OFS_PHASE); // Phase read hit
  wire [31:0] ctrl_word = 32'(dual_q) << CTRL_DUAL_BIT; // Control view
  wire [31:0] stat_word = (32'(pos_q) << ST_POS_LSB) | (32'(dir_q) << ST_DIR_BIT)
    | (32'(mode_q) << ST_MODE_LSB) | (32'(logic_standby) << ST_STBY_BIT);
  wire [31:0] phase_word = (32'(phase_a_code) << PH_A_LSB)
    | (32'(phase_a_neg) << PH_A_NEG_BIT) | (32'(phase_b_code) << PH_B_LSB)
    | (32'(phase_b_neg) << PH_B_NEG_BIT);
  wire [31:0] rd_mux = rd_ctrl ? ctrl_word : rd_stat ? stat_word
    : rd_phase ? phase_word : 32'h0000_0000;
  // Write channels and control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      dual_q <= CTRL_DUAL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wr_ctrl && wstrb_q[0])
          dual_q <= wdata_q[CTRL_DUAL_BIT];
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (rd_ctrl || rd_stat || rd_phase) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_live_step;
    step_evt && !stby_now && !seq_rst;
  endsequence
  a_rise_moves_pos: assert property (step_rise && !stby_now && !seq_rst |=> pos_q != $past(pos_q)) // RQ4
    else $error("rising step edge did not move position");
  a_fall_ignored: assert property (step_fall && !dual_q && !seq_rst |=> $stable(pos_q)) // RQ4
    else $error("falling edge moved position in standard variant");
  a_dual_fall_moves: assert property (step_fall && dual_q && !stby_now && !seq_rst |=> $changed(pos_q)) // RQ5
    else $error("falling edge ignored in dual edge variant");
  a_hold_no_edge: assert property (!step_evt && !seq_rst |=> $stable(pos_q)) // RQ3
    else $error("position moved without a step edge");
  a_standby_hold: assert property (stby_now && !seq_rst |=> $stable(pos_q)) // RQ11
    else $error("position moved in standby");
  a_pin_reset: assert property (seq_rst |=> pos_q == POS_RESET ##1 phase_a_code == 4'h8) // RQ9
    else $error("reset pin did not restore start position");
  a_grid_visit: assert property (s_live_step |=> (pos_q & ($past(stride_now) - 5'd1)) == 5'd0) // RQ8
    else $error("step landed off the mode grid");
  a_fwd_wrap: assert property (s_live_step ##0 !dir_now && sel_now == MSEL_SIXTEENTH
    |=> pos_q == 5'($past(pos_q) + 5'd1)) // RQ12
    else $error("forward sixteenth step did not add one");
  a_rev_dir: assert property (s_live_step ##0 dir_now && sel_now == MSEL_SIXTEENTH
    |=> pos_q == 5'($past(pos_q) - 5'd1)) // RQ2
    else $error("reverse sixteenth step did not subtract one");
  a_start_codes: assert property ($rose(pos_q == POS_RESET) |=> phase_a_code == 4'h8
    && phase_b_code == 4'h8 && !phase_a_neg && !phase_b_neg) // RQ7
    else $error("start position codes wrong");
endmodule
`default_nettype wire

// [test_stepper_step_sequencer.sv]
// Testbench for the stepper step sequencer
`timescale 1ns/1ps
`default_nettype none
module test_stepper_step_sequencer;
  import step_seq_pkg::*;
  // ==========================================
  // Signals
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, stby, fullc, an, bn;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] ac, bc;
  wire logic stp, dir, m0, m1, m2, rst;
  int n_mismatch = 0, n_tests = 0;
  step_ctrl_model ctl (.aclk(aclk), .step_clk_pin(stp), .rotation_direction_sel(dir),
    .step_res_sel_bit0(m0), .step_res_sel_bit1(m1), .step_res_sel_bit2(m2),
    .seq_reset_pin(rst));
  stepper_step_sequencer dut (.aclk(aclk), .aresetn(aresetn), .step_clk_pin(stp),
    .rotation_direction_sel(dir), .step_res_sel_bit0(m0), .step_res_sel_bit1(m1),
    .step_res_sel_bit2(m2), .seq_reset_pin(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .phase_a_code(ac), .phase_a_neg(an), .phase_b_code(bc),
    .phase_b_neg(bn), .logic_standby(stby), .full_current_mode(fullc));
  // ==========================================
  // Clock
  initial
  begin
    forever #20 aclk = ~aclk;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && awready === 1'b1)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  // Read and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // Address held until the edge at which arready is sampled high
    do
      @(posedge aclk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    // Data taken at the edge at which rvalid is sampled high
    do
      @(posedge aclk);
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(OFS_PHASE, 32'h0000_0808, RESP_OKAY);
    rd(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
  endtask
  task automatic t_fine();
    ctl.set_pins(1'b0, MSEL_SIXTEENTH);
    repeat (3) ctl.pulse();
    rd(OFS_STATUS, 32'h0000_3003, RESP_OKAY);
    rd(OFS_PHASE, 32'h0000_0B05, RESP_OKAY);
    chk("phase_b_code", 32'h0000_000B, {28'h0, bc});
  endtask
  task automatic t_mode();
    ctl.set_pins(1'b0, MSEL_QUARTER);
    ctl.pulse();
    rd(OFS_STATUS, 32'h0000_1004, RESP_OKAY);
    ctl.set_pins(1'b1, MSEL_FULL8);
    ctl.pulse();
    rd(OFS_STATUS, 32'h0000_0100, RESP_OKAY);
    ctl.pulse();
    rd(OFS_STATUS, 32'h0000_0110, RESP_OKAY);
    rd(OFS_PHASE, 32'h0000_0818, RESP_OKAY);
    chk("phase_a_code", 32'h0000_0008, {28'h0, ac});
    chk("phase_a_neg", 32'h1, {31'h0, an});
    chk("phase_b_neg", 32'h0, {31'h0, bn});
  endtask
  task automatic t_standby();
    ctl.set_pins(1'b1, MSEL_STANDBY);
    chk("logic_standby", 32'h1, {31'h0, stby});
    ctl.pulse();
    rd(OFS_PHASE, 32'h0000_0818, RESP_OKAY);
    ctl.set_pins(1'b0, MSEL_FULLF);
    chk("full_current_mode", 32'h1, {31'h0, fullc});
  endtask
  task automatic t_dual();
    wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    ctl.set_pins(1'b0, MSEL_EIGHTH);
    ctl.pulse();
    rd(OFS_STATUS, 32'h0000_5014, RESP_OKAY);
    rd(OFS_PHASE, 32'h0000_041C, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
  endtask
  task automatic t_pin_reset();
    ctl.reset_seq();
    rd(OFS_PHASE, 32'h0000_0808, RESP_OKAY);
    ctl.set_pins(1'b0, MSEL_HALF);
    ctl.pulse();
    rd(OFS_PHASE, 32'h0000_0F00, RESP_OKAY);
    ctl.set_pins(1'b0, MSEL_HALFF);
    chk("full_current_mode", 32'h1, {31'h0, fullc});
    ctl.pulse();
    rd(OFS_STATUS, 32'h0000_6010, RESP_OKAY);
  endtask
  task automatic t_bus();
    rd(8'h0C, 32'h0000_0000, RESP_SLVERR);
    wr(8'h10, 32'h0000_0001, RESP_SLVERR);
    rd(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
  endtask
  // ==========================================
  // Verdict and run
  task automatic end_sim();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_fine();
    t_mode();
    t_standby();
    t_dual();
    t_pin_reset();
    t_bus();
    end_sim();
  end
endmodule
`default_nettype wire
